// [pkg/dee_pkg.sv]
// Package for the data EEPROM access controller and its processor-side driver.
// Assumes a single 250 MHz clock shared by both ends.
package dee_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int MEM_BYTES = 512;
	localparam int ROW_BYTES = 64;
	localparam logic [7:0] OFS_ADDR = 8'hf2;
	localparam logic [7:0] OFS_CTRL = 8'hf1;
	localparam logic [7:0] OFS_DATA = 8'hf3;
	localparam int BIT_A8 = 0;
	localparam int BIT_SEL_LO = 4;
	localparam int BIT_HV_ERROR = 6;
	localparam int BIT_DONE = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h31;
	localparam int CLK_MHZ = 250;
	localparam int PROG_TIME_US = 4000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int READ_CYCLES = 3;
	localparam logic [7:0] HOST_OFS_CMD = 8'h00;
	localparam logic [7:0] HOST_OFS_STAT = 8'h04;
	localparam logic [7:0] HOST_OFS_MASK = 8'h08;
	localparam logic [7:0] HOST_OFS_RDATA = 8'h0c;
	typedef enum logic [1:0] {
		DEE_SEL_BYTE = 2'b00,
		DEE_SEL_RSVD = 2'b01,
		DEE_SEL_ROW = 2'b10,
		DEE_SEL_BLOCK = 2'b11
	} dee_sel_e;
endpackage

// [pkg/dee_if.sv]
// Special function register bus between processor side and the EEPROM block.
// Assumes both ends on the same clock; read data valid the cycle after rd.
`timescale 1ns/100ps
interface dee_if;
	logic       wr;
	logic       rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       irq;
	modport dev (input wr, rd, addr, wdata, output rdata, irq);
	modport cpu (output wr, rd, addr, wdata, input rdata, irq);
endinterface

// [design/dee_timer.sv]
// Down counter giving the busy time of one EEPROM operation.
// Assumes load only while idle.
`timescale 1ns/100ps
module dee_timer #(
	parameter int CNT_W = 20
) (
	input  wire logic             clk,   // Clock
	input  wire logic             rst_n, // Async reset
	input  wire logic             load,  // Start pulse
	input  wire logic [CNT_W-1:0] count, // Cycles to run
	output logic                  busy,  // Running
	output logic                  done   // Pulse in the cycle after busy ends
);
	logic [CNT_W-1:0] cnt_reg;

	if (CNT_W < 2) begin : g_cnt_check
		$error("dee_timer: CNT_W too small");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_reg <= count;
				busy    <= 1'b1;
			end else if (busy) begin
				if (cnt_reg <= 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 1'b1;
				end
			end
		end
	end
endmodule

// [design/dee_ctrl.sv]
// Data EEPROM access controller: address, control/status and data registers.
// Assumes processor writes through dee_if; irq gated by enables from outside.
`timescale 1ns/100ps
module dee_ctrl
	import dee_pkg::*;
#(
	parameter int PROG_CNT = PROG_CYCLES
) (
	input  wire logic clk,          // Clock 250 MHz
	input  wire logic rst_n,        // Async reset, any hardware reset
	dee_if.dev        bus,          // Register bus
	input  wire logic hv_fault,     // Programming voltage fault
	input  wire logic irq_enable,   // Eeprom interrupt enable
	input  wire logic global_irq_en // Global interrupt enable
);
	import dee_pkg::*;

	localparam int CNT_W = $clog2(PROG_CNT + 1) + 1;

	logic [DATA_W-1:0] mem [MEM_BYTES];
	logic [7:0]        addr_lo_reg;
	logic [7:0]        ctrl_reg;
	logic [7:0]        data_reg;
	logic [7:0]        rdata_reg;
	logic              irq_reg;
	logic              pend_reg;
	logic              hv_s1_reg;
	logic              hv_s2_reg;
	logic [1:0]        kind_reg;
	logic [8:0]        op_addr_reg;
	logic [7:0]        op_data_reg;
	logic              t_load;
	logic [CNT_W-1:0]  t_count;
	logic              busy;
	logic              done;
	dee_sel_e          sel;

	if (PROG_CNT < READ_CYCLES) begin : g_cnt_check
		$error("dee_ctrl: PROG_CNT too small");
	end

	assign sel = dee_sel_e'(ctrl_reg[BIT_SEL_LO +: 2]);

	// Reserved select code starts nothing
	function automatic logic starts_op(input dee_sel_e s);
		return s != DEE_SEL_RSVD;
	endfunction

	wire wr_addr = bus.wr && bus.addr == OFS_ADDR;
	wire wr_ctrl = bus.wr && bus.addr == OFS_CTRL;
	wire wr_data = bus.wr && bus.addr == OFS_DATA;

	// Triggers while busy are dropped
	assign t_load = wr_addr && !busy && starts_op(sel);
	always_comb begin
		if (sel == DEE_SEL_BYTE && !pend_reg)
			t_count = CNT_W'(READ_CYCLES);
		else
			t_count = CNT_W'(PROG_CNT);
	end

	dee_timer #(.CNT_W(CNT_W)) u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (t_load),
		.count (t_count),
		.busy  (busy),
		.done  (done)
	);

	// Fault pin is asynchronous to us
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hv_s1_reg <= 1'b0;
			hv_s2_reg <= 1'b0;
		end else begin
			hv_s1_reg <= hv_fault;
			hv_s2_reg <= hv_s1_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 1'b0;
		end else if (wr_data && sel == DEE_SEL_BYTE && !busy) begin
			pend_reg <= 1'b1;
		end else if (t_load) begin
			pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_lo_reg <= 8'h00;
			data_reg    <= 8'h00;
		end else begin
			if (wr_addr && !busy)
				addr_lo_reg <= bus.wdata;
			if (wr_data && !busy)
				data_reg <= bus.wdata;
			else if (done && kind_reg == 2'b01)
				data_reg <= mem[op_addr_reg];
		end
	end

	// kind: 00 none, 01 read, 10 program
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kind_reg    <= 2'b00;
			op_addr_reg <= 9'h000;
			op_data_reg <= 8'h00;
		end else if (t_load) begin
			kind_reg    <= (sel == DEE_SEL_BYTE && !pend_reg) ? 2'b01 : 2'b10;
			op_addr_reg <= {ctrl_reg[BIT_A8], bus.wdata};
			op_data_reg <= data_reg;
		end
	end

	dee_sel_e op_sel_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			op_sel_reg <= DEE_SEL_BYTE;
		else if (t_load)
			op_sel_reg <= sel;
	end

	// Array update at the end of the busy time
	always_ff @(posedge clk) begin
		if (done && kind_reg == 2'b10 && !hv_s2_reg) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				if (op_sel_reg == DEE_SEL_BLOCK)
					mem[i] <= op_data_reg;
				else if (op_sel_reg == DEE_SEL_ROW
					&& i[8:6] == op_addr_reg[8:6])
					mem[i] <= op_data_reg;
				else if (op_sel_reg == DEE_SEL_BYTE && i[8:0] == op_addr_reg)
					mem[i] <= op_data_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			if (wr_ctrl && !busy)
				ctrl_reg <= (ctrl_reg & ~CTRL_WMASK) | (bus.wdata & CTRL_WMASK);
			// Writing zero clears a flag; hardware set wins
			if (wr_ctrl && !bus.wdata[BIT_DONE])
				ctrl_reg[BIT_DONE] <= 1'b0;
			if (wr_ctrl && !bus.wdata[BIT_HV_ERROR])
				ctrl_reg[BIT_HV_ERROR] <= 1'b0;
			if (done)
				ctrl_reg[BIT_DONE] <= 1'b1;
			if (busy && kind_reg == 2'b10 && hv_s2_reg)
				ctrl_reg[BIT_HV_ERROR] <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
			irq_reg   <= 1'b0;
		end else begin
			irq_reg <= ctrl_reg[BIT_DONE] && irq_enable && global_irq_en;
			if (bus.rd) begin
				unique case (bus.addr)
					OFS_ADDR: rdata_reg <= addr_lo_reg;
					OFS_CTRL: rdata_reg <= {ctrl_reg[7:4], 3'b000, ctrl_reg[0]};
					OFS_DATA: rdata_reg <= data_reg;
					default:  rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	assign bus.rdata = rdata_reg;
	assign bus.irq   = irq_reg;
endmodule

// [design/dee_host.sv]
// Processor-side end: turns software commands into register bus sequences.
// Assumes software polls status; one command at a time.
`timescale 1ns/100ps
module dee_host
	import dee_pkg::*;
(
	input  wire logic       clk,      // Clock
	input  wire logic       rst_n,    // Async reset
	input  wire logic [7:0] sw_addr,  // Software address
	input  wire logic [7:0] sw_wdata, // Software write data
	input  wire logic       sw_wr,    // Software write strobe
	input  wire logic       sw_rd,    // Software read strobe
	output logic      [7:0] sw_rdata, // Read data, cycle after sw_rd
	output logic            sw_irq,   // Interrupt level
	dee_if.cpu              bus       // Device bus
);
	import dee_pkg::*;

	typedef enum logic [2:0] {
		DEE_H_IDLE = 3'b000, DEE_H_CTRL = 3'b001, DEE_H_DATA = 3'b010,
		DEE_H_ADDR = 3'b011, DEE_H_POLL = 3'b100, DEE_H_WAIT = 3'b101,
		DEE_H_GET  = 3'b110, DEE_H_CLR  = 3'b111
	} dee_hstate_e;

	dee_hstate_e state_reg;
	logic [15:0] cmd_reg;   // {ctl, addr}
	logic [7:0]  pat_reg;
	logic        wdat_reg;
	logic [7:0]  rd_reg;
	logic [1:0]  stat_reg;
	logic [1:0]  mask_reg;
	logic        wr_reg, rd_q_reg;
	logic        cap_reg;
	logic [7:0]  a_reg, d_reg, out_reg;

	wire start = sw_wr && sw_addr == HOST_OFS_CMD && state_reg == DEE_H_IDLE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DEE_H_IDLE;
			cmd_reg <= 16'h0000; pat_reg <= 8'h00; wdat_reg <= 1'b0;
			rd_reg <= 8'h00; wr_reg <= 1'b0; rd_q_reg <= 1'b0;
			cap_reg <= 1'b0;
			a_reg <= 8'h00; d_reg <= 8'h00;
		end else begin
			wr_reg <= 1'b0; rd_q_reg <= 1'b0;
			cap_reg <= 1'b0;
			// Device answers a cycle after the data read, not in the clear state
			if (cap_reg) rd_reg <= bus.rdata;
			if (sw_wr && sw_addr == HOST_OFS_RDATA) pat_reg <= sw_wdata;
			unique case (state_reg)
				DEE_H_IDLE: if (start) begin
					// wdata[7] asks for a data write; bits 5:4 and 0 as control
					cmd_reg <= {sw_wdata & CTRL_WMASK, cmd_reg[7:0]};
					wdat_reg <= sw_wdata[7];
					state_reg <= DEE_H_CTRL;
				end else if (sw_wr && sw_addr == HOST_OFS_CMD + 8'h01) begin
					cmd_reg[7:0] <= sw_wdata;
				end
				DEE_H_CTRL: begin
					wr_reg <= 1'b1; a_reg <= OFS_CTRL; d_reg <= cmd_reg[15:8];
					state_reg <= wdat_reg ? DEE_H_DATA : DEE_H_ADDR;
				end
				DEE_H_DATA: begin
					wr_reg <= 1'b1; a_reg <= OFS_DATA; d_reg <= pat_reg;
					state_reg <= DEE_H_ADDR;
				end
				DEE_H_ADDR: begin
					wr_reg <= 1'b1; a_reg <= OFS_ADDR; d_reg <= cmd_reg[7:0];
					state_reg <= DEE_H_POLL;
				end
				DEE_H_POLL: begin
					rd_q_reg <= 1'b1; a_reg <= OFS_CTRL;
					state_reg <= DEE_H_WAIT;
				end
				DEE_H_WAIT: state_reg <= DEE_H_GET;
				DEE_H_GET: if (bus.rdata[BIT_DONE]) begin
					rd_q_reg <= 1'b1; a_reg <= OFS_DATA;
					state_reg <= DEE_H_CLR;
				end else begin
					state_reg <= DEE_H_POLL;
				end
				DEE_H_CLR: begin
					cap_reg <= 1'b1;
					wr_reg <= 1'b1; a_reg <= OFS_CTRL; d_reg <= cmd_reg[15:8];
					state_reg <= DEE_H_IDLE;
				end
			endcase
		end
	end

	// Status: bit0 done, bit1 voltage error; write one to clear
	logic hv_seen;
	assign hv_seen = state_reg == DEE_H_GET && bus.rdata[BIT_DONE] && bus.rdata[BIT_HV_ERROR];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= 2'b00; mask_reg <= 2'b00;
			out_reg <= 8'h00; sw_irq <= 1'b0;
		end else begin
			if (sw_wr && sw_addr == HOST_OFS_MASK) mask_reg <= sw_wdata[1:0];
			stat_reg <= (stat_reg & ~((sw_wr && sw_addr == HOST_OFS_STAT) ? sw_wdata[1:0] : 2'b00))
				| {hv_seen, state_reg == DEE_H_CLR};
			sw_irq <= |(stat_reg & mask_reg);
			if (sw_rd) begin
				unique case (sw_addr)
					HOST_OFS_CMD:   out_reg <= {state_reg != DEE_H_IDLE, 7'h00};
					HOST_OFS_STAT:  out_reg <= {6'h00, stat_reg};
					HOST_OFS_MASK:  out_reg <= {6'h00, mask_reg};
					HOST_OFS_RDATA: out_reg <= rd_reg;
					default:        out_reg <= 8'h00;
				endcase
			end
		end
	end

	assign sw_rdata  = out_reg;
	assign bus.wr    = wr_reg;
	assign bus.rd    = rd_q_reg;
	assign bus.addr  = a_reg;
	assign bus.wdata = d_reg;
endmodule

// [bench/dee_chk.sv]
// Assertions on the register bus between host and EEPROM controller.
// Assumes the host clears the done flag before each new operation.
`timescale 1ns/100ps
module dee_chk
	import dee_pkg::*;
#(
	parameter int PROG_CNT = 20
) (
	input wire logic       clk,          // Clock
	input wire logic       rst_n,        // Reset
	input wire logic       wr,           // Write
	input wire logic       rd,           // Read
	input wire logic [7:0] addr,         // Offset
	input wire logic [7:0] wdata,        // Write data
	input wire logic [7:0] rdata,        // Read data
	input wire logic       irq,          // Interrupt
	input wire logic       irq_enable,   // Enable
	input wire logic       global_irq_en // Global enable
);
	logic [1:0]  sel_reg;
	logic        a8_reg, pend_reg, prog_reg, act_reg, rdc_reg, clr_reg, busy, trig, cwr;
	logic [15:0] age_reg, agec_reg;
	int          lim;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	assign lim = prog_reg ? PROG_CNT + 1 : READ_CYCLES + 1;
	assign busy = act_reg && age_reg <= 16'(lim + 1);
	assign cwr = wr && addr == OFS_CTRL;
	assign trig = wr && addr == OFS_ADDR && !busy && sel_reg != DEE_SEL_RSVD;
	// Shadow of mode and pending write; busy writes are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_reg <= 2'h0;
			a8_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			if (cwr && !busy) begin
				sel_reg <= wdata[5:4];
				a8_reg <= wdata[0];
			end
			if (trig || (wr && addr == OFS_DATA && !busy && sel_reg == DEE_SEL_BYTE))
				pend_reg <= !trig;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_reg <= 1'b0;
			prog_reg <= 1'b0;
			age_reg <= 16'h0;
		end else if (trig) begin
			act_reg <= 1'b1;
			prog_reg <= pend_reg || sel_reg != DEE_SEL_BYTE;
			age_reg <= 16'h0;
		end else if (age_reg != 16'hffff) begin
			age_reg <= age_reg + 16'h1;
		end
	end
	// Windows allow one cycle either way of the set point
	always_ff @(posedge clk) begin
		rdc_reg <= rd && addr == OFS_CTRL;
		agec_reg <= age_reg;
		clr_reg <= !trig && (clr_reg || (cwr && !wdata[7] && age_reg >= 16'(lim + 2)));
	end
	property p_early;
		rdc_reg && act_reg && agec_reg + 16'h2 <= 16'(lim) |-> !rdata[7];
	endproperty
	a_early: assert property (p_early) else $error("Done flag too early");
	property p_late;
		rdc_reg && act_reg && !clr_reg && agec_reg >= 16'(lim + 2) |-> rdata[7];
	endproperty
	a_late: assert property (p_late) else $error("Done flag missing");
	property p_sel; rdc_reg |-> rdata[5:4] == $past(sel_reg); endproperty
	a_sel: assert property (p_sel) else $error("Mode readback wrong");
	property p_a8; rdc_reg |-> rdata[0] == $past(a8_reg); endproperty
	a_a8: assert property (p_a8) else $error("Address bit readback wrong");
	property p_rsvd; rdc_reg |-> rdata[3:1] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved bits not zero");
	property p_irq_off; !(irq_enable && global_irq_en) |=> !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("Interrupt while disabled");
	property p_irq_on;
		rdc_reg && rdata[7] && $past(irq_enable) && $past(global_irq_en) |-> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("Interrupt missing");
	property p_hold; !rd |=> $stable(rdata); endproperty
	a_hold: assert property (p_hold) else $error("Read data changed");
endmodule

// [bench/data_eeprom_access_controller_tb.sv]
// Bench joining host and controller over the register bus.
// Assumes the host map: address, pattern, command, status, mask.
`timescale 1ns/100ps
module data_eeprom_access_controller_tb;
	import dee_pkg::*;
	localparam int PROG_CNT = 20;
	logic       clk = 1'b0, rst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, hv_fault = 1'b0;
	logic       irq_enable = 1'b1, global_irq_en = 1'b1, exp_irq = 1'b0, sw_irq;
	logic [7:0] sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata, rd_val;
	int         miscompares = 0, total_checks = 0;
	dee_if dee_if_i ();
	dee_ctrl #(.PROG_CNT(PROG_CNT)) dee_ctrl_i (.clk(clk), .rst_n(rst_n), .bus(dee_if_i.dev),
		.hv_fault(hv_fault), .irq_enable(irq_enable), .global_irq_en(global_irq_en));
	dee_host dee_host_i (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sw_irq(sw_irq), .bus(dee_if_i.cpu));
	dee_chk #(.PROG_CNT(PROG_CNT)) dee_chk_i (.clk(clk), .rst_n(rst_n), .wr(dee_if_i.wr),
		.rd(dee_if_i.rd), .addr(dee_if_i.addr), .wdata(dee_if_i.wdata), .rdata(dee_if_i.rdata),
		.irq(dee_if_i.irq), .irq_enable(irq_enable), .global_irq_en(global_irq_en));
	always #2 clk = ~clk;
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Checks made %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask
	// Data stand from the cycle after the strobe until the next read
	task automatic sw_read(input logic [7:0] a);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 rd_val = sw_rdata;
	endtask
	task automatic reset_pulse();
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	function automatic logic [7:0] ctl(input logic [1:0] s, input logic a8);
		return {2'h0, s, 3'h0, a8};
	endfunction
	// One host command, then poll, status check and flag clear
	task automatic op(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
			input logic [7:0] stat);
		sw_write(HOST_OFS_CMD + 8'h01, a);
		sw_write(HOST_OFS_RDATA, d);
		sw_write(HOST_OFS_CMD, c);
		repeat (3) @(posedge clk);
		rd_val = 8'hff;
		for (int i = 0; i < 100 && rd_val[7] !== 1'b0; i++)
			sw_read(HOST_OFS_CMD);
		chk("busy", rd_val & 8'h80, 8'h00);
		chk("irq", {7'h0, sw_irq}, {7'h0, exp_irq});
		sw_read(HOST_OFS_STAT);
		chk("status", rd_val & 8'h03, stat);
		sw_write(HOST_OFS_STAT, 8'h03);
		@(posedge clk);
		#1 chk("irq clear", {7'h0, sw_irq}, 8'h00);
	endtask
	task automatic wr_b(input logic [8:0] a, input logic [7:0] d, input logic [7:0] stat);
		op(ctl(DEE_SEL_BYTE, a[8]) | 8'h80, a[7:0], d, stat);
	endtask
	task automatic rd_b(input logic [8:0] a, input logic [7:0] exp);
		op(ctl(DEE_SEL_BYTE, a[8]), a[7:0], 8'h00, 8'h01);
		sw_read(HOST_OFS_RDATA);
		chk("read data", rd_val, exp);
	endtask
	// Longest path is 14 operations of under 100 cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		sw_write(8'h10, 8'hff);
		sw_read(HOST_OFS_MASK);
		chk("mask", rd_val, 8'h00);
		sw_read(HOST_OFS_STAT);
		chk("status", rd_val, 8'h00);
		$display("Test reset done");
		wr_b(9'h1a5, 8'h5a, 8'h01);
		wr_b(9'h0a5, 8'hc3, 8'h01);
		rd_b(9'h1a5, 8'h5a);
		rd_b(9'h0a5, 8'hc3);
		$display("Test byte done");
		sw_write(HOST_OFS_MASK, 8'h01);
		exp_irq = 1'b1;
		op(ctl(DEE_SEL_ROW, 1'b0) | 8'h80, 8'h47, 8'h3c, 8'h01);
		rd_b(9'h040, 8'h3c);
		rd_b(9'h07f, 8'h3c);
		rd_b(9'h0a5, 8'hc3);
		$display("Test row fill done");
		@(posedge clk);
		hv_fault <= 1'b1;
		global_irq_en <= 1'b0;
		wr_b(9'h0a5, 8'h11, 8'h03);
		@(posedge clk);
		hv_fault <= 1'b0;
		global_irq_en <= 1'b1;
		rd_b(9'h0a5, 8'hc3);
		$display("Test fault done");
		@(posedge clk);
		irq_enable <= 1'b0;
		op(ctl(DEE_SEL_BLOCK, 1'b1) | 8'h80, 8'h00, 8'h96, 8'h01);
		@(posedge clk);
		irq_enable <= 1'b1;
		rd_b(9'h000, 8'h96);
		rd_b(9'h1ff, 8'h96);
		$display("Test block fill done");
		// Reserved mode never completes, so the host stays busy until reset
		sw_write(HOST_OFS_CMD + 8'h01, 8'h12);
		sw_write(HOST_OFS_CMD, ctl(DEE_SEL_RSVD, 1'b0) | 8'h80);
		repeat (40) @(posedge clk);
		sw_read(HOST_OFS_CMD);
		chk("reserved busy", rd_val, 8'h80);
		sw_read(HOST_OFS_STAT);
		chk("reserved status", rd_val, 8'h00);
		$display("Test reserved mode done");
		reset_pulse();
		// Reset lands after the data write, before the address write
		sw_write(HOST_OFS_CMD + 8'h01, 8'ha5);
		sw_write(HOST_OFS_RDATA, 8'h55);
		sw_write(HOST_OFS_CMD, ctl(DEE_SEL_BYTE, 1'b0) | 8'h80);
		repeat (3) @(posedge clk);
		reset_pulse();
		exp_irq = 1'b0;
		sw_read(HOST_OFS_STAT);
		chk("status", rd_val, 8'h00);
		rd_b(9'h0a5, 8'h96);
		$display("Test second reset done");
		conclude();
	end
endmodule
